//--- hdl/iprl_regs.sv
/*
 * Two 16-bit interrupt priority level registers behind an AHB-Lite slave.
 * The first covers serial port 0 and timer A channels 1 to 3, the second
 * the PWM fault/reload and ADC interrupts. Each 2-bit field is decoded
 * into an enable and a level for the interrupt arbitration logic, and the
 * raw requests of the peripherals are gated by that enable.
 * One small field decoder module, instanced per source, follows the top.
 * Assumes a single AHB-Lite master, a single clock hclk and asynchronous
 * active-low reset hresetn; peripheral requests are synchronous to hclk.
 */
`timescale 1ns/10ps
`default_nettype none
`include "iprl_defines.svh"

// Overview of operation
// - Field 00 disables its request; reset value
// - Fields 01,10,11 map to levels 0,1,2
// - All fields reset to zero, sources disabled
// - First register bits 11-10 read zero, unwritable
// - Register index 8; bits 15-14 uart0 rx full
// - First register bits 13-12 uart0 rx error
// - First register bits 9-8 uart0 tx idle
// - First register bits 7-6 uart0 tx empty
// - First register bits 5-4 timer A channel 3
// - Bits 3-2 timer A ch2, 1-0 ch1
// - Second register index 9; PWM A/B fault levels
// - Second register bits 11-8 PWM A/B reload levels
// - Second register bits 7-4 ADC A/B zero-limit
// - Second register bits 3-2 ADC A done
// - Second register bits 1-0 ADC B done
module iprl_regs #(
  parameter int NUM_SRC = `IPRL_NUM_SRC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [NUM_SRC-1:0] src_req,
  output logic [NUM_SRC-1:0] arb_req,
  output iprl_pkg::iprl_src_level_t [NUM_SRC-1:0] src_level
);

  // ========================================================================
  // Declarations
  // ========================================================================
  iprl_pkg::iprl_addr_phase_t aph_q;
  iprl_pkg::iprl_addr_phase_t aph_d;
  logic [`IPRL_REG_W-1:0] serial_timer_irq_levels_q;
  logic [`IPRL_REG_W-1:0] serial_timer_irq_levels_d;
  logic [`IPRL_REG_W-1:0] pwm_adc_irq_levels_q;
  logic [`IPRL_REG_W-1:0] pwm_adc_irq_levels_d;
  logic [31:0] hrdata_q;
  logic [31:0] hrdata_d;
  logic hreadyout_q;
  logic hresp_q;
  logic [NUM_SRC-1:0] arb_req_q;
  // Nets: each field decoder drives its own slice
  wire logic [NUM_SRC-1:0] arb_req_d;
  iprl_pkg::iprl_src_level_t [NUM_SRC-1:0] src_level_q;
  wire iprl_pkg::iprl_src_level_t [NUM_SRC-1:0] src_level_d;
  logic take_addr;
  logic addr_word;

  // ========================================================================
  // AHB-Lite address phase
  // ========================================================================
  // Zero-wait slave: every transfer completes in one data-phase cycle, so
  // hreadyout stays high and non-word sizes or unaligned addresses are refused (ignored).
  assign take_addr = hsel && hready && htrans[1];
  assign addr_word = (hsize == `IPRL_HSIZE_WORD) && (haddr[1:0] == 2'h0);

  always_comb begin
    aph_d = aph_q;
    if (hready) begin
      aph_d.valid = take_addr && addr_word;
      aph_d.write = hwrite;
      aph_d.addr = haddr[`IPRL_ADDR_W-1:0];
    end
  end

  // ========================================================================
  // Register writes in the data phase
  // ========================================================================
  // Upper address bits are not decoded: the block is expected to sit in a
  // small window chosen by the system decoder through hsel.
  always_comb begin
    serial_timer_irq_levels_d = serial_timer_irq_levels_q;
    pwm_adc_irq_levels_d = pwm_adc_irq_levels_q;
    if (aph_q.valid && aph_q.write) begin
      case (aph_q.addr)
        `IPRL_SERIAL_TIMER_ADDR: begin
          // Reserved bits 11-10 are masked off and so always read zero
          serial_timer_irq_levels_d = hwdata[`IPRL_REG_W-1:0]
                                      & `IPRL_SERIAL_TIMER_WMASK;
        end
        `IPRL_PWM_ADC_ADDR: begin
          pwm_adc_irq_levels_d = hwdata[`IPRL_REG_W-1:0]
                                 & `IPRL_PWM_ADC_WMASK;
        end
        default: begin
        end
      endcase
    end
  end

  // ========================================================================
  // Read data, registered so it stands in the data phase
  // ========================================================================
  // Read data is taken from the current register contents during the
  // address phase; a write in the preceding data phase is forwarded so a
  // back-to-back write then read returns the new value.
  always_comb begin
    hrdata_d = 32'h0000_0000;
    if (take_addr && addr_word && !hwrite) begin
      case (haddr[`IPRL_ADDR_W-1:0])
        `IPRL_SERIAL_TIMER_ADDR: begin
          hrdata_d = {16'h0000, serial_timer_irq_levels_d};
        end
        `IPRL_PWM_ADC_ADDR: begin
          hrdata_d = {16'h0000, pwm_adc_irq_levels_d};
        end
        default: begin
          hrdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  // ========================================================================
  // Field decode and request gating, one decoder per source
  // ========================================================================
  // Decoded from the next register values so the arbiter sees a new level
  // in the same cycle as software reads it back.
  iprl_field_dec uart0_rx_full_u (
    .field(serial_timer_irq_levels_d[`IPRL_POS_UART0_RX_FULL +: 2]),
    .req(src_req[0]),
    .enabled(src_level_d[0].enabled),
    .level(src_level_d[0].level),
    .req_gated(arb_req_d[0])
  );
  iprl_field_dec uart0_rx_error_u (
    .field(serial_timer_irq_levels_d[`IPRL_POS_UART0_RX_ERROR +: 2]),
    .req(src_req[1]),
    .enabled(src_level_d[1].enabled),
    .level(src_level_d[1].level),
    .req_gated(arb_req_d[1])
  );
  iprl_field_dec uart0_tx_idle_u (
    .field(serial_timer_irq_levels_d[`IPRL_POS_UART0_TX_IDLE +: 2]),
    .req(src_req[2]),
    .enabled(src_level_d[2].enabled),
    .level(src_level_d[2].level),
    .req_gated(arb_req_d[2])
  );
  iprl_field_dec uart0_tx_empty_u (
    .field(serial_timer_irq_levels_d[`IPRL_POS_UART0_TX_EMPTY +: 2]),
    .req(src_req[3]),
    .enabled(src_level_d[3].enabled),
    .level(src_level_d[3].level),
    .req_gated(arb_req_d[3])
  );
  iprl_field_dec timer_a_ch3_u (
    .field(serial_timer_irq_levels_d[`IPRL_POS_TIMER_A_CH3 +: 2]),
    .req(src_req[4]),
    .enabled(src_level_d[4].enabled),
    .level(src_level_d[4].level),
    .req_gated(arb_req_d[4])
  );
  iprl_field_dec timer_a_ch2_u (
    .field(serial_timer_irq_levels_d[`IPRL_POS_TIMER_A_CH2 +: 2]),
    .req(src_req[5]),
    .enabled(src_level_d[5].enabled),
    .level(src_level_d[5].level),
    .req_gated(arb_req_d[5])
  );
  iprl_field_dec timer_a_ch1_u (
    .field(serial_timer_irq_levels_d[`IPRL_POS_TIMER_A_CH1 +: 2]),
    .req(src_req[6]),
    .enabled(src_level_d[6].enabled),
    .level(src_level_d[6].level),
    .req_gated(arb_req_d[6])
  );

  // Sources 7 to 14 live in the second register
  iprl_field_dec pwm_unit_a_fault_u (
    .field(pwm_adc_irq_levels_d[`IPRL_POS_PWM_A_FAULT +: 2]),
    .req(src_req[7]),
    .enabled(src_level_d[7].enabled),
    .level(src_level_d[7].level),
    .req_gated(arb_req_d[7])
  );
  iprl_field_dec pwm_unit_b_fault_u (
    .field(pwm_adc_irq_levels_d[`IPRL_POS_PWM_B_FAULT +: 2]),
    .req(src_req[8]),
    .enabled(src_level_d[8].enabled),
    .level(src_level_d[8].level),
    .req_gated(arb_req_d[8])
  );
  iprl_field_dec pwm_unit_a_reload_u (
    .field(pwm_adc_irq_levels_d[`IPRL_POS_PWM_A_RELOAD +: 2]),
    .req(src_req[9]),
    .enabled(src_level_d[9].enabled),
    .level(src_level_d[9].level),
    .req_gated(arb_req_d[9])
  );
  iprl_field_dec pwm_unit_b_reload_u (
    .field(pwm_adc_irq_levels_d[`IPRL_POS_PWM_B_RELOAD +: 2]),
    .req(src_req[10]),
    .enabled(src_level_d[10].enabled),
    .level(src_level_d[10].level),
    .req_gated(arb_req_d[10])
  );
  iprl_field_dec adc_a_zero_limit_u (
    .field(pwm_adc_irq_levels_d[`IPRL_POS_ADC_A_ZERO_LIMIT +: 2]),
    .req(src_req[11]),
    .enabled(src_level_d[11].enabled),
    .level(src_level_d[11].level),
    .req_gated(arb_req_d[11])
  );
  iprl_field_dec adc_b_zero_limit_u (
    .field(pwm_adc_irq_levels_d[`IPRL_POS_ADC_B_ZERO_LIMIT +: 2]),
    .req(src_req[12]),
    .enabled(src_level_d[12].enabled),
    .level(src_level_d[12].level),
    .req_gated(arb_req_d[12])
  );
  iprl_field_dec adc_a_done_u (
    .field(pwm_adc_irq_levels_d[`IPRL_POS_ADC_A_DONE +: 2]),
    .req(src_req[13]),
    .enabled(src_level_d[13].enabled),
    .level(src_level_d[13].level),
    .req_gated(arb_req_d[13])
  );
  iprl_field_dec adc_b_done_u (
    .field(pwm_adc_irq_levels_d[`IPRL_POS_ADC_B_DONE +: 2]),
    .req(src_req[14]),
    .enabled(src_level_d[14].enabled),
    .level(src_level_d[14].level),
    .req_gated(arb_req_d[14])
  );

  // ========================================================================
  // State registers
  // ========================================================================
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_q <= '0;
      serial_timer_irq_levels_q <= `IPRL_RESET_VAL;
      pwm_adc_irq_levels_q <= `IPRL_RESET_VAL;
      hrdata_q <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
      hresp_q <= `IPRL_HRESP_OKAY;
      arb_req_q <= '0;
      src_level_q <= '0;
    end else begin
      aph_q <= aph_d;
      serial_timer_irq_levels_q <= serial_timer_irq_levels_d;
      pwm_adc_irq_levels_q <= pwm_adc_irq_levels_d;
      hrdata_q <= hrdata_d;
      hreadyout_q <= 1'b1;
      hresp_q <= `IPRL_HRESP_OKAY;
      arb_req_q <= arb_req_d;
      src_level_q <= src_level_d;
    end
  end

  // ========================================================================
  // Outputs
  // ========================================================================
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign hrdata = hrdata_q;
  assign arb_req = arb_req_q;
  assign src_level = src_level_q;

endmodule // iprl_regs

// ==========================================================================
// Field decoder: one level field to an enable, a level and a request gate
// ==========================================================================
module iprl_field_dec #(
  parameter int FIELD_W = 2
) (
  input wire logic [FIELD_W-1:0] field,
  input wire logic req,
  output logic enabled,
  output logic [FIELD_W-1:0] level,
  output logic req_gated
);

  always_comb begin
    enabled = (field != `IPRL_FIELD_DISABLED);
    // Codes 01,10,11 become 0,1,2; off still shows 0, so enable must be used
    level = enabled ? (field - FIELD_W'(1)) : '0;
    // A disabled source never reaches arbitration
    req_gated = req && enabled;
  end

endmodule // iprl_field_dec

`default_nettype wire

//--- hdl/iprl_defines.svh
/*
 * Constants for the interrupt priority level registers: register indices,
 * byte addresses, field positions, masks and reset values.
 * Assumes inclusion by bare name from any file that needs them.
 */
`ifndef IPRL_DEFINES_SVH
`define IPRL_DEFINES_SVH

// ==========================================================================
// Register map
// ==========================================================================
`define IPRL_SERIAL_TIMER_IDX 8
`define IPRL_PWM_ADC_IDX 9
`define IPRL_SERIAL_TIMER_ADDR 8'h20
`define IPRL_PWM_ADC_ADDR 8'h24
`define IPRL_ADDR_W 8
`define IPRL_REG_W 16
`define IPRL_RESET_VAL 16'h0000
`define IPRL_SERIAL_TIMER_WMASK 16'hf3ff
`define IPRL_PWM_ADC_WMASK 16'hffff

// ==========================================================================
// Field positions (low bit of each 2-bit field)
// ==========================================================================
`define IPRL_NUM_SRC 15
`define IPRL_POS_UART0_RX_FULL 14
`define IPRL_POS_UART0_RX_ERROR 12
`define IPRL_POS_UART0_TX_IDLE 8
`define IPRL_POS_UART0_TX_EMPTY 6
`define IPRL_POS_TIMER_A_CH3 4
`define IPRL_POS_TIMER_A_CH2 2
`define IPRL_POS_TIMER_A_CH1 0
`define IPRL_POS_PWM_A_FAULT 14
`define IPRL_POS_PWM_B_FAULT 12
`define IPRL_POS_PWM_A_RELOAD 10
`define IPRL_POS_PWM_B_RELOAD 8
`define IPRL_POS_ADC_A_ZERO_LIMIT 6
`define IPRL_POS_ADC_B_ZERO_LIMIT 4
`define IPRL_POS_ADC_A_DONE 2
`define IPRL_POS_ADC_B_DONE 0

// ==========================================================================
// Field encoding
// ==========================================================================
`define IPRL_FIELD_DISABLED 2'h0

// ==========================================================================
// AHB-Lite encodings
// ==========================================================================
`define IPRL_HTRANS_IDLE 2'h0
`define IPRL_HTRANS_NONSEQ 2'h2
`define IPRL_HSIZE_WORD 3'h2
`define IPRL_HRESP_OKAY 1'h0

`endif

//--- hdl/iprl_pkg.sv
/*
 * Types shared by the interrupt priority level register block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package iprl_pkg;

  // ========================================================================
  // Per-source level presented to the arbiter
  // ========================================================================
  typedef struct packed {
    logic enabled;
    logic [1:0] level;
  } iprl_src_level_t;

  // ========================================================================
  // Captured AHB address phase
  // ========================================================================
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } iprl_addr_phase_t;

endpackage
`default_nettype wire

//--- sim/iprl_regs_monitor.sv
/* Checker on the ports of the priority level register block.
   Assumes one clock hclk and async reset hresetn; bound below. */
`timescale 1ns/10ps
`default_nettype none
module iprl_regs_monitor #(
  parameter int NUM_SRC = 15
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [NUM_SRC-1:0] src_req,
  input wire logic [NUM_SRC-1:0] arb_req,
  input wire iprl_pkg::iprl_src_level_t [NUM_SRC-1:0] src_level
);
  logic [NUM_SRC-1:0] en_v;
  logic bad_enc, acc, rd20_d, wr24_d, rd20_q, wr24_q;
  // ==========
  // Data phase tracking
  always_comb begin
    bad_enc = 1'b0;
    for (int i = 0; i < NUM_SRC; i++) begin
      en_v[i] = src_level[i].enabled;
      bad_enc = bad_enc | (src_level[i].level == 2'h3) | (!en_v[i] && |src_level[i].level);
    end
    acc = hsel && hready && htrans[1];
    rd20_d = acc && !hwrite && haddr[7:0] == 8'h20;
    wr24_d = acc && hwrite && haddr[7:0] == 8'h24;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) {rd20_q, wr24_q} <= 2'h0;
    else {rd20_q, wr24_q} <= {rd20_d, wr24_d};
  end
  // ==========
  // Properties
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_bus_ok; hreadyout && !hresp; endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus answer late or not okay");
  property p_enc; !bad_enc; endproperty
  a_enc: assert property (p_enc) else $error("level encoding wrong");
  // Stable enables make the gate independent of when a write lands
  property p_gate; $stable(en_v) |-> arb_req == ($past(src_req) & en_v); endproperty
  a_gate: assert property (p_gate) else $error("request gate wrong");
  property p_rsv; rd20_q |-> hrdata[11:10] == 2'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
  property p_upper; hrdata[31:16] == 16'h0000; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_wr_pwm; wr24_q |=> src_level[7].enabled == (|$past(hwdata[15:14])); endproperty
  a_wr_pwm: assert property (p_wr_pwm) else $error("pwm fault enable wrong");
  property p_wr_adc;
    wr24_q |=> src_level[14].level ==
      ($past(hwdata[1:0]) == 2'h0 ? 2'h0 : $past(hwdata[1:0]) - 2'h1);
  endproperty
  a_wr_adc: assert property (p_wr_adc) else $error("adc done level wrong");
  property p_rst; $rose(hresetn) |-> en_v == '0 && arb_req == '0; endproperty
  a_rst: assert property (p_rst) else $error("sources live after reset");
  c_rd20: cover property (rd20_q);
  c_wr24: cover property (wr24_q);
  c_gate: cover property (|arb_req);
endmodule // iprl_regs_monitor
bind iprl_regs iprl_regs_monitor #(.NUM_SRC(NUM_SRC)) mon_u (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .src_req(src_req), .arb_req(arb_req), .src_level(src_level));
`default_nettype wire

//--- sim/iprl_src_model.sv
/* Peripheral request sources facing the register block.
   Raises the level requests asked for, just after a clock edge. */
`timescale 1ns/10ps
`default_nettype none
module iprl_src_model #(
  parameter int NUM_SRC = 15
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [NUM_SRC-1:0] want,
  output logic [NUM_SRC-1:0] src_req
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) src_req <= '0;
    else src_req <= want;
  end
endmodule // iprl_src_model
`default_nettype wire

//--- sim/tb_iprl_regs.sv
/* Self-checking bench for the priority level registers.
   Drives AHB-Lite and the request sources; the checker is bound in. */
`timescale 1ns/10ps
`default_nettype none
`include "iprl_defines.svh"
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin bad_count++; \
  $display("ERROR %s exp %h got %h", n, e, s); end end
module tb_iprl_regs;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_pend = 1'b0;
  logic [1:0] htrans = `IPRL_HTRANS_IDLE;
  logic [2:0] hsize = `IPRL_HSIZE_WORD;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, seed = 32'h0000_a390;
  logic [31:0] hrdata, v, e_v;
  logic [14:0] want = 15'h0000, src_req, arb_req, en_m;
  logic [15:0] r8, r9;
  logic hreadyout, hresp;
  iprl_pkg::iprl_src_level_t [14:0] src_level;
  logic [31:0] exp_q[$];
  int bad_count = 0;
  int num_checks = 0;
  localparam int POS[15] = '{14, 12, 8, 6, 4, 2, 0, 14, 12, 10, 8, 6, 4, 2, 0};
  iprl_regs #(.NUM_SRC(15)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .src_req(src_req),
    .arb_req(arb_req), .src_level(src_level));
  iprl_src_model #(.NUM_SRC(15)) src_u (.hclk(hclk), .hresetn(hresetn), .want(want),
    .src_req(src_req));
  initial begin
    forever #2.5 hclk = ~hclk;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // ==========
  // Bus master: address held until hready, then data phase until hready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= `IPRL_HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= `IPRL_HTRANS_IDLE;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back({16'h0000, e});
    bus(1'b0, a, xs());
  endtask
  // Read data is taken at the edge that ends its data phase
  always @(posedge hclk) begin
    if (rd_pend) begin
      e_v = exp_q.pop_front();
      `CHK("hrdata", e_v, hrdata)
    end
    rd_pend <= hsel && htrans[1] && !hwrite && hreadyout;
  end
  task automatic levels();
    logic [1:0] f;
    iprl_pkg::iprl_src_level_t e;
    #1;
    for (int i = 0; i < 15; i++) begin
      f = (i < 7) ? r8[POS[i] +: 2] : r9[POS[i] +: 2];
      e.enabled = (f != 2'h0);
      e.level = (f == 2'h0) ? 2'h0 : f - 2'h1;
      en_m[i] = e.enabled;
      `CHK("src_level", e, src_level[i])
    end
  endtask
  task automatic final_report();
    if (bad_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #40000;
    bad_count++;
    final_report();
  end
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    for (int k = 0; k < 14; k++) begin
      @(posedge hclk);
      if (k == 0 || k == 13) begin
        r8 = 16'h0000;
        r9 = 16'h0000;
        levels();
        @(posedge hclk);
        rd(8'h20, 16'h0000);
        rd(8'h24, 16'h0000);
        if (k == 13) break;
      end
      v = xs();
      // All ones on the second pass, to hit the reserved pair
      if (k == 1) v = 32'hffff_ffff;
      bus(1'b1, 8'h20, v);
      r8 = v[15:0] & `IPRL_SERIAL_TIMER_WMASK;
      v = xs();
      bus(1'b1, 8'h24, v);
      r9 = v[15:0];
      bus(1'b1, 8'h28, 32'hffff_ffff);
      rd(8'h20, r8);
      rd(8'h24, r9);
      rd(8'h28, 16'h0000);
      levels();
      v = xs();
      @(posedge hclk);
      want <= v[14:0];
      repeat (2) @(posedge hclk);
      #1 `CHK("arb_req", v[14:0] & en_m, arb_req)
      if (k == 12) begin
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
      end
    end
    repeat (2) @(posedge hclk);
    final_report();
  end
endmodule // tb_iprl_regs
`default_nettype wire
